// ==== hw/shb_host_bus.sv ====
// host bus interface: strobe sync, register file, acknowledge cycle
`timescale 1ns/1ps
`default_nettype none
module shb_host_bus
  import shb_pkg::*;
#(
  parameter int unsigned NSRC = 6
)(
  input  wire logic              i_ref_clk,
  input  wire logic              i_resetn,
  input  wire logic              i_cs_n,
  input  wire logic              i_rd_n,
  input  wire logic              i_wr_n,
  input  wire logic              i_irq_acknowledge_n,
  input  wire logic              i_chan_a,
  input  wire logic              i_data_sel,
  input  wire logic [7:0]        i_db,
  input  wire logic              i_chain_enable_in,
  input  wire logic [NSRC-1:0]   i_irq_pending,
  input  wire logic [7:0]        i_rx_data_a,
  input  wire logic [7:0]        i_rx_data_b,
  input  wire logic [7:0]        i_rd_stat_a,
  input  wire logic [7:0]        i_rd_stat_b,
  output logic [7:0]             o_db,
  output logic                   o_db_oe,
  output logic                   o_chain_enable_out,
  output logic [NSRC-1:0]        o_in_service_flag,
  output logic [7:0]             o_shared_vector_reg,
  output logic [7:0]             o_master_interrupt_control_reg,
  output logic [7:0]             o_transmit_buffer_reg_a,
  output logic [7:0]             o_transmit_buffer_reg_b,
  output logic                   o_tx_load_a,
  output logic                   o_tx_load_b,
  output logic [8*REG_NUM-1:0]   o_regs_a,
  output logic [8*REG_NUM-1:0]   o_regs_b,
  output logic                   o_recovery_ok
);
  ////////////////////////////////////////////////////////////////////////////
  // strobe synchronisation
  logic [3:0] syn;
  shb_sync #(.W(4)) u_sync (
    .i_ref_clk (i_ref_clk),
    .i_resetn  (i_resetn),
    .i_async   ({i_cs_n, i_rd_n, i_wr_n, i_irq_acknowledge_n}),
    .i_rst_val (4'hF),
    .o_sync    (syn)
  );
  wire cs_s   = ~syn[3];
  wire rd_s   = ~syn[2];
  wire wr_s   = ~syn[1];
  wire ack_s  = ~syn[0];
  // effective read gated by chip select
  wire rd_act = cs_s & rd_s & ~ack_s;
  // effective write gated by chip select
  wire wr_act = cs_s & wr_s;
  logic rd_d_ff, wr_d_ff, ia_d_ff;
  wire  ia_act  = ack_s & rd_s;
  wire  wr_rise = wr_act & ~wr_d_ff;
  wire  rd_rise = rd_act & ~rd_d_ff;
  wire  ia_rise = ia_act & ~ia_d_ff;
  wire  rd_fall = ~rd_act & rd_d_ff;

  ////////////////////////////////////////////////////////////////////////////
  // register addressing
  logic [7:0] ptr_a_ff, ptr_b_ff;
  logic [7:0] regs_a_ff [REG_NUM];
  logic [7:0] regs_b_ff [REG_NUM];
  logic [7:0] vec_ff, mic_ff;
  wire [7:0] ptr_sel = i_chan_a ? ptr_a_ff : ptr_b_ff;
  function automatic logic [3:0] ptr_idx(input logic [7:0] p);
    ptr_idx = {p[PTR_HI_BIT] & ~p[PTR_F4_BIT] & ~p[PTR_F5_BIT], p[2:0]};
  endfunction : ptr_idx
  // data select goes straight to data register
  wire [3:0] idx     = i_data_sel ? REG_TXBUF : ptr_idx(ptr_sel);
  wire       ind_acc = ~i_data_sel && (ptr_idx(ptr_sel) != REG_PTR);
  wire       is_shrd = (idx == REG_VECTOR) || (idx == REG_MIC);

  ////////////////////////////////////////////////////////////////////////////
  // write path
  integer k;
  always_ff @(posedge i_ref_clk or negedge i_resetn)
    if (!i_resetn)
    begin
      rd_d_ff  <= 1'b0;
      wr_d_ff  <= 1'b0;
      ia_d_ff  <= 1'b0;
      ptr_a_ff <= REG_RST;
      ptr_b_ff <= REG_RST;
      vec_ff   <= REG_RST;
      mic_ff   <= REG_RST;
      for (k = 0; k < REG_NUM; k++)
      begin
        regs_a_ff[k] <= REG_RST;
        regs_b_ff[k] <= REG_RST;
      end
    end
    else
    begin
      rd_d_ff <= rd_act;
      wr_d_ff <= wr_act;
      ia_d_ff <= ia_act;
      if (wr_rise && !ind_acc && !i_data_sel)
      begin
        if (i_chan_a)
          ptr_a_ff <= i_db;
        else
          ptr_b_ff <= i_db;
      end
      else if ((wr_rise || rd_rise) && ind_acc)
      begin
        if (i_chan_a)
          ptr_a_ff <= ptr_a_ff & PTR_CLR_MASK;
        else
          ptr_b_ff <= ptr_b_ff & PTR_CLR_MASK;
      end
      if (wr_rise && (ind_acc || i_data_sel))
      begin
        if (is_shrd && idx == REG_VECTOR)
          vec_ff <= i_db;
        else if (is_shrd)
          mic_ff <= i_db;
        else if (i_chan_a)
          regs_a_ff[idx] <= i_db;
        else
          regs_b_ff[idx] <= i_db;
      end
    end
  assign o_tx_load_a = wr_rise & i_chan_a & (idx == REG_TXBUF) & (ind_acc | i_data_sel);
  assign o_tx_load_b = wr_rise & ~i_chan_a & (idx == REG_TXBUF) & (ind_acc | i_data_sel);

  genvar g;
  generate
    for (g = 0; g < REG_NUM; g++)
    begin : g_regs
      assign o_regs_a[8*g +: 8] = regs_a_ff[g];
      assign o_regs_b[8*g +: 8] = regs_b_ff[g];
    end
  endgenerate
  assign o_shared_vector_reg            = vec_ff;
  assign o_master_interrupt_control_reg = mic_ff;
  assign o_transmit_buffer_reg_a        = regs_a_ff[REG_TXBUF];
  assign o_transmit_buffer_reg_b        = regs_b_ff[REG_TXBUF];

  ////////////////////////////////////////////////////////////////////////////
  // acknowledge cycle and daisy chain
  logic [NSRC-1:0] ius_ff;
  logic            claim_ff;
  logic [7:0]      db_ff;
  logic            oe_ff;
  wire [NSRC-1:0] act_pend = i_irq_pending & ~ius_ff;
  wire [NSRC-1:0] top_src  = act_pend & (~act_pend + 1'b1);
  wire            any_pend = |act_pend;
  // chain settles combinationally before the read strobe
  assign o_chain_enable_out = i_chain_enable_in & ~any_pend & ~(|ius_ff);
  // claim needs pending and chain enable at acknowledge read start
  wire claim    = ia_rise & any_pend & i_chain_enable_in;
  wire vis      = mic_ff[MIC_VIS_BIT];
  wire [7:0] rd_mux = i_data_sel ? (i_chan_a ? i_rx_data_a : i_rx_data_b) :
                      (idx == REG_VECTOR) ? vec_ff :
                      (i_chan_a ? i_rd_stat_a : i_rd_stat_b);
  always_ff @(posedge i_ref_clk or negedge i_resetn)
    if (!i_resetn)
    begin
      ius_ff   <= '0;
      claim_ff <= 1'b0;
      db_ff    <= REG_RST;
      oe_ff    <= 1'b0;
    end
    else
    begin
      if (claim)
        ius_ff <= ius_ff | top_src;
      if (claim)
        claim_ff <= 1'b1;
      else if (!ia_act)
        claim_ff <= 1'b0;
      if (claim)
        db_ff <= vec_ff;
      else if (rd_rise)
        db_ff <= rd_mux;
      if (claim)
        oe_ff <= vis;
      else if (rd_rise)
        oe_ff <= 1'b1;
      else if (!ia_act && !rd_act)
        oe_ff <= 1'b0;
      else if (ia_rise)
        oe_ff <= 1'b0;
    end
  assign o_db              = db_ff;
  assign o_db_oe           = oe_ff;
  assign o_in_service_flag = ius_ff;

  ////////////////////////////////////////////////////////////////////////////
  // recovery watch, informational
  logic [7:0] rec_ff;
  always_ff @(posedge i_ref_clk or negedge i_resetn)
    if (!i_resetn)
      rec_ff <= 8'h00;
    else if (rd_act || wr_act)
      rec_ff <= 8'h00;
    else if (rec_ff != 8'(REC_CYC))
      rec_ff <= rec_ff + 8'h01;
  // host spacing visible to the core
  // only accesses with chip select count
  assign o_recovery_ok = (rec_ff == 8'(REC_CYC));

  ////////////////////////////////////////////////////////////////////////////
  // checks
  claim_ius_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    claim |=> (ius_ff == ($past(ius_ff) | $past(top_src)))) else $error("ius not set");
  no_claim_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (ia_rise && !i_chain_enable_in) |=> ius_ff == $past(ius_ff)) else $error("bad claim");
  float_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (ia_rise && !claim) |=> !o_db_oe) else $error("bus driven");
  vec_drv_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (claim && vis) |=> (o_db_oe && o_db == $past(vec_ff))) else $error("vector missing");
  ptr_clr_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (wr_rise && ind_acc && i_chan_a) |=> ptr_a_ff[4:0] == 5'h00) else $error("ptr kept");
  shared_wr_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (wr_rise && ind_acc && idx == REG_VECTOR) |=> vec_ff == $past(i_db)) else $error("vec");
  cs_gate_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    !cs_s |=> $stable(regs_a_ff[REG_TXBUF])) else $error("write without cs");
  chain_out_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    any_pend |-> !o_chain_enable_out) else $error("chain passes");
  rec_a: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    rd_fall |-> ##[1:8] !o_recovery_ok) else $error("recovery");
  claim_c: cover property (@(posedge i_ref_clk) disable iff (!i_resetn) claim && vis);
  shrd_c:  cover property (@(posedge i_ref_clk) disable iff (!i_resetn) wr_rise && is_shrd);
  data_c:  cover property (@(posedge i_ref_clk) disable iff (!i_resetn) o_tx_load_b);
endmodule : shb_host_bus
`default_nettype wire

// ==== hw/shb_pkg.sv ====
// package: constants and carriers for the host bus interface
package shb_pkg;
  localparam int unsigned DATA_W       = 8;
  localparam int unsigned REG_NUM      = 16;
  localparam logic [3:0]  REG_PTR      = 4'h0;
  localparam logic [3:0]  REG_VECTOR   = 4'h2;
  localparam logic [3:0]  REG_TXBUF    = 4'h8;
  localparam logic [3:0]  REG_MIC      = 4'h9;
  localparam int unsigned PTR_HI_BIT   = 3;
  localparam int unsigned PTR_F4_BIT   = 4;
  localparam int unsigned PTR_F5_BIT   = 5;
  localparam logic [7:0]  PTR_CLR_MASK = 8'hE0;
  localparam logic [7:0]  REG_RST      = 8'h00;
  localparam int unsigned MIC_VIS_BIT  = 1;
  localparam int unsigned SYNC_STAGES  = 3;
  localparam int unsigned CLK_NS       = 20;
  localparam int unsigned REC_CYC_MIN  = 6;
  localparam int unsigned REC_EXTRA_NS = 130;
  localparam int unsigned REC_CYC      = REC_CYC_MIN + (REC_EXTRA_NS + CLK_NS - 1) / CLK_NS;

  typedef struct packed {
    logic        chan_a;
    logic        data_sel;
    logic [7:0]  wdata;
  } shb_acc_s;

  typedef struct packed {
    logic        we;
    logic        chan_a;
    logic [3:0]  idx;
    logic [7:0]  data;
  } shb_wr_s;
endpackage : shb_pkg

// ==== hw/shb_sync.sv ====
// three-stage synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module shb_sync
  import shb_pkg::*;
#(
  parameter int unsigned W = 4
)(
  input  wire logic         i_ref_clk,
  input  wire logic         i_resetn,
  input  wire logic [W-1:0] i_async,
  input  wire logic [W-1:0] i_rst_val,
  output logic [W-1:0]      o_sync
);
  logic [W-1:0] s1_ff, s2_ff, s3_ff, q_ff;
  wire  [W-1:0] agree = ~(s2_ff ^ s3_ff);
  wire  [W-1:0] nxt_q = (agree & s3_ff) | (~agree & q_ff);
  always_ff @(posedge i_ref_clk or negedge i_resetn)
    if (!i_resetn)
    begin
      s1_ff <= '1;
      s2_ff <= '1;
      s3_ff <= '1;
      q_ff  <= '1;
    end
    else
    begin
      s1_ff <= i_async;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      q_ff  <= nxt_q;
    end
  // i_rst_val unused by design: strobes idle high, reset to ones
  assign o_sync = q_ff | (i_rst_val & ~i_rst_val);
endmodule : shb_sync
`default_nettype wire

// ==== verif/shb_host_bus_bench.sv ====
// self-checking bench for the host bus interface
`timescale 1ns/1ps
`default_nettype none
module shb_host_bus_bench;
  import shb_pkg::*;
  logic         ref_clk  = 1'b0;
  logic         resetn   = 1'b0;
  logic         chain_in = 1'b0;
  logic [5:0]   pend     = 6'h00;
  logic         cs_n, rd_n, wr_n, ack_n;
  shb_acc_s     acc;
  logic [7:0]   db, vec, mic, txa, txb;
  logic         db_oe, chain_out, ld_a, ld_b, rec_ok;
  logic [5:0]   in_service_flag;
  logic [127:0] regs_a, regs_b;
  logic [8:0]   q;
  int           error_cnt   = 0;
  int           checks_done = 0;
  int           cyc         = 0;

  always #10 ref_clk = ~ref_clk;

  shb_host_model i_host (.i_ref_clk(ref_clk), .i_db(db), .i_db_oe(db_oe), .o_cs_n(cs_n),
    .o_rd_n(rd_n), .o_wr_n(wr_n), .o_ack_n(ack_n), .o_acc(acc));

  shb_host_bus #(.NSRC(6)) i_dut (.i_ref_clk(ref_clk), .i_resetn(resetn), .i_cs_n(cs_n),
    .i_rd_n(rd_n), .i_wr_n(wr_n), .i_irq_acknowledge_n(ack_n), .i_chan_a(acc.chan_a),
    .i_data_sel(acc.data_sel), .i_db(acc.wdata), .i_chain_enable_in(chain_in),
    .i_irq_pending(pend), .i_rx_data_a(8'hA5), .i_rx_data_b(8'h5A),
    .i_rd_stat_a(8'h3C), .i_rd_stat_b(8'hC3), .o_db(db), .o_db_oe(db_oe),
    .o_chain_enable_out(chain_out), .o_in_service_flag(in_service_flag), .o_shared_vector_reg(vec),
    .o_master_interrupt_control_reg(mic), .o_transmit_buffer_reg_a(txa),
    .o_transmit_buffer_reg_b(txb), .o_tx_load_a(ld_a), .o_tx_load_b(ld_b),
    .o_regs_a(regs_a), .o_regs_b(regs_b), .o_recovery_ok(rec_ok));

  task automatic chk(input string nm, input logic [8:0] exp, input logic [8:0] got);
    checks_done++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic complete_run();
    if (error_cnt == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : complete_run

  // pointer write, then the indirect write it selects
  task automatic wr_reg(input logic a, input logic [7:0] p, input logic [7:0] d);
    i_host.cycle(1'b1, 1'b1, 1'b0, '{a, 1'b0, p}, q);
    i_host.cycle(1'b1, 1'b1, 1'b0, '{a, 1'b0, d}, q);
  endtask : wr_reg

  task automatic t_indirect();
    wr_reg(1'b1, 8'h23, 8'h5C);
    chk("a_reg3", {1'b0, 8'h5C}, {1'b0, regs_a[31:24]});
    // pointer index now back at zero: next command write must reload it, not hit reg3
    i_host.cycle(1'b1, 1'b1, 1'b0, '{1'b1, 1'b0, 8'h01}, q);
    i_host.cycle(1'b1, 1'b1, 1'b0, '{1'b1, 1'b0, 8'hEE}, q);
    chk("a_reg1", {1'b0, 8'hEE}, {1'b0, regs_a[15:8]});
    chk("a_reg3_kept", {1'b0, 8'h5C}, {1'b0, regs_a[31:24]});
    chk("b_reg3", 9'h000, {1'b0, regs_b[31:24]});
    wr_reg(1'b0, 8'h0B, 8'hC3);
    chk("b_reg11", {1'b0, 8'hC3}, {1'b0, regs_b[95:88]});
    wr_reg(1'b0, 8'h1B, 8'h3C);
    chk("b_reg3", {1'b0, 8'h3C}, {1'b0, regs_b[31:24]});
    chk("rec_ok", 9'h001, {8'h00, rec_ok});
  endtask : t_indirect

  task automatic t_shared();
    wr_reg(1'b0, 8'h02, 8'h7E);
    chk("vector", {1'b0, 8'h7E}, {1'b0, vec});
    wr_reg(1'b1, 8'h09, 8'h02);
    chk("mic", {1'b0, 8'h02}, {1'b0, mic});
  endtask : t_shared

  task automatic t_direct();
    i_host.cycle(1'b1, 1'b1, 1'b0, '{1'b1, 1'b1, 8'h96}, q);
    chk("txbuf_a", {1'b0, 8'h96}, {1'b0, txa});
    chk("txbuf_b", 9'h000, {1'b0, txb});
    i_host.cycle(1'b0, 1'b1, 1'b0, '{1'b1, 1'b1, 8'h11}, q);
    chk("txbuf_a", {1'b0, 8'h96}, {1'b0, txa});
    i_host.cycle(1'b1, 1'b0, 1'b0, '{1'b1, 1'b1, 8'h00}, q);
    chk("rd_a", {1'b1, 8'hA5}, q);
    i_host.cycle(1'b1, 1'b0, 1'b0, '{1'b0, 1'b1, 8'h00}, q);
    chk("rd_b", {1'b1, 8'h5A}, q);
    i_host.cycle(1'b0, 1'b0, 1'b0, '{1'b0, 1'b1, 8'h00}, q);
    chk("rd_nocs", 9'h000, {q[8], 8'h00});
  endtask : t_direct

  task automatic t_ack();
    @(posedge ref_clk);
    pend <= 6'h0C;
    i_host.cycle(1'b0, 1'b0, 1'b1, '{1'b0, 1'b0, 8'h00}, q);
    chk("ack_off", 9'h000, {q[8], 8'h00});
    chain_in <= 1'b1;
    pend     <= 6'h00;
    i_host.cycle(1'b0, 1'b0, 1'b1, '{1'b0, 1'b0, 8'h00}, q);
    chk("ack_idle", 9'h000, {q[8], 8'h00});
    chk("chain_o", 9'h001, {8'h00, chain_out});
    pend <= 6'h0C;
    i_host.cycle(1'b0, 1'b0, 1'b1, '{1'b0, 1'b0, 8'h00}, q);
    chk("ack_vec", {1'b1, 8'h7E}, q);
    chk("in_serv", 9'h004, {3'h0, in_service_flag});
    chk("chain_o", 9'h000, {8'h00, chain_out});
  endtask : t_ack

  // hang guard, about ten times the expected run
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 8000)
    begin
      error_cnt++;
      complete_run();
    end
  end

  initial
  begin
    repeat (4) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (6) @(posedge ref_clk);
    t_indirect();
    t_shared();
    t_direct();
    t_ack();
    complete_run();
  end
endmodule : shb_host_bus_bench
`default_nettype wire

// ==== verif/shb_host_model.sv ====
// host bus master model driving the device strobes
`timescale 1ns/1ps
`default_nettype none
module shb_host_model
  import shb_pkg::*;
(
  input  wire logic       i_ref_clk,
  input  wire logic [7:0] i_db,
  input  wire logic       i_db_oe,
  output var logic        o_cs_n,
  output var logic        o_rd_n,
  output var logic        o_wr_n,
  output var logic        o_ack_n,
  output var shb_acc_s    o_acc
);
  initial
  begin
    o_cs_n  = 1'b1;
    o_rd_n  = 1'b1;
    o_wr_n  = 1'b1;
    o_ack_n = 1'b1;
    o_acc   = '0;
  end

  // one strobe; q returns {oe, data} sampled late in the strobe
  task automatic cycle(input logic cs, input logic wr, input logic ack,
                       input shb_acc_s acc, output logic [8:0] q);
    @(posedge i_ref_clk);
    o_acc   <= acc;
    o_cs_n  <= ~cs;
    o_ack_n <= ~ack;
    repeat (ack ? 4 : 1) @(posedge i_ref_clk);
    o_rd_n <= wr;
    o_wr_n <= ~wr;
    repeat (8) @(posedge i_ref_clk);
    @(negedge i_ref_clk);
    q = {i_db_oe, i_db};
    @(posedge i_ref_clk);
    o_rd_n  <= 1'b1;
    o_wr_n  <= 1'b1;
    o_cs_n  <= 1'b1;
    o_ack_n <= 1'b1;
    // released bus shows the inverse, not a stale copy
    o_acc.wdata <= ~acc.wdata;
    repeat (2 * REC_CYC) @(posedge i_ref_clk);
  endtask : cycle
endmodule : shb_host_model
`default_nettype wire
